//--- pkg/refmon_pkg.sv
// Package: register map, field layout and timing constants of the reference supervisor
package refmon_pkg;
    localparam int NUM_REFS = 4;
    localparam int ADDR_W = 12;
    localparam int PERIOD_W = 40;
    localparam int TOL_W = 20;
    localparam int TIMER_W = 16;
    localparam int MEAS_W = 40;

    // Printed offsets, byte-wide registers on the plain port
    localparam logic [11:0] FORCE_VALIDATION_TIMEOUT_ADDR = 12'hA0E;
    localparam logic [11:0] MONITOR_OVERRIDE_CONTROL_ADDR = 12'hA0F;
    localparam logic [11:0] MONITOR_BYPASS_CONTROL_ADDR = 12'hA10;
    localparam logic [11:0] REF_STATUS_ADDR = 12'hA11;
    localparam logic [11:0] PROFILE_SEL_ADDR = 12'hA12;
    localparam logic [11:0] PROFILE_BASE_ADDR = 12'hA20;
    localparam logic [11:0] PROFILE_STRIDE = 12'h010;

    // Byte positions within one profile block
    localparam logic [3:0] PRF_PERIOD_B0 = 4'h0;
    localparam logic [3:0] PRF_INNER_B0 = 4'h5;
    localparam logic [3:0] PRF_OUTER_B0 = 4'h8;
    localparam logic [3:0] PRF_VALID_B0 = 4'hB;
    localparam logic [3:0] PRF_REDET_B0 = 4'hD;
    localparam logic [3:0] PRF_LAST = 4'hE;

    // Reset values
    localparam logic [7:0] OVERRIDE_RESET = 8'h00;
    localparam logic [7:0] BYPASS_RESET = 8'h00;

    // Timing: system clock and derived 1 ms tick
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int SYS_PERIOD_FS = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = SYS_CLK_HZ / 1000 * TICK_MS;
    // Arbitrary stability wait, kept short so that a simulation stays brief
    localparam int STABLE_MS = 1;
    localparam int STABLE_CYCLES = SYS_CLK_HZ / 1000 * STABLE_MS;

    typedef struct packed {
        logic [PERIOD_W-1:0] period_fs;
        logic [TOL_W-1:0] inner_tol;
        logic [TOL_W-1:0] outer_tol;
        logic [TIMER_W-1:0] valid_ms;
        logic [TIMER_W-1:0] redet_ms;
    } profile_t;

    typedef struct packed {
        logic bypass;
        logic override;
        logic force_to;
    } ctrl_bits_t;

    typedef struct packed {
        logic valid;
        logic faulted;
        logic redetect;
    } ref_status_t;
endpackage

//--- logic/ref_channel.sv
// One reference channel: period monitor, validation and redetect timers, valid latch
`timescale 1ns/10ps
module ref_channel
    import refmon_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stable,
    input wire logic tick_ms,
    input wire logic ref_in,
    input wire profile_t prof,
    input wire ctrl_bits_t ctrl,
    input wire logic auto_sel,
    output ref_status_t status
);
    typedef struct packed {
        logic ref_d_r;
        logic seen_r;
        logic [MEAS_W-1:0] meas_r;
        logic mon_fault_r;
        logic faulted_r;
        logic [TIMER_W-1:0] vcnt_r;
        logic [TIMER_W-1:0] rcnt_r;
        logic valid_r;
        logic redet_r;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic edge_in;
    logic [MEAS_W-1:0] dev;
    logic [MEAS_W+TOL_W-1:0] dev_scaled_in;
    logic [MEAS_W+TOL_W-1:0] dev_scaled_out;
    logic in_inner;
    logic in_outer;
    logic faulted_now;
    logic v_expire;

    assign edge_in = ref_in && !st_r.ref_d_r;
    assign dev = (st_r.meas_r > prof.period_fs) ? st_r.meas_r - prof.period_fs
                                                 : prof.period_fs - st_r.meas_r;
    // Deviation * (1/tol) <= period  <=>  |dP|/P <= tol; avoids a divider
    assign dev_scaled_in = dev * prof.inner_tol;
    assign dev_scaled_out = dev * prof.outer_tol;
    assign in_inner = dev_scaled_in <= {{TOL_W{1'b0}}, prof.period_fs};
    assign in_outer = dev_scaled_out <= {{TOL_W{1'b0}}, prof.period_fs};
    // Faulted source selection
    assign faulted_now = ctrl.bypass ? ctrl.override // [R17]
                                     : (ctrl.override || st_r.mon_fault_r); // [R16] [R18]
    assign v_expire = tick_ms && (prof.valid_ms != '0) && !faulted_now
                      && (st_r.vcnt_r + 16'h0001 == prof.valid_ms); // [R9]

    always_comb begin
        st_nxt = st_r;
        st_nxt.ref_d_r = ref_in;
        st_nxt.faulted_r = faulted_now;
        if (!stable) begin
            st_nxt.mon_fault_r = 1'b1; // [R1]
            st_nxt.seen_r = 1'b0;
            st_nxt.meas_r = '0;
        end else if (edge_in) begin
            st_nxt.seen_r = 1'b1;
            // Edge cycle already counts as one elapsed clock, else rise to rise reads short
            st_nxt.meas_r = MEAS_W'(SYS_PERIOD_FS); // [R2]
            if (st_r.seen_r) begin
                // Hysteresis: inner to leave fault, outer to enter it
                if (st_r.mon_fault_r) begin
                    st_nxt.mon_fault_r = !in_inner; // [R2] [R5]
                end else begin
                    st_nxt.mon_fault_r = !in_outer; // [R6]
                end
            end
        end else begin
            // Saturating count also catches a dead reference
            if (st_r.meas_r < {MEAS_W{1'b1}} - MEAS_W'(SYS_PERIOD_FS)) begin
                st_nxt.meas_r = st_r.meas_r + MEAS_W'(SYS_PERIOD_FS); // [R3]
            end else begin
                st_nxt.mon_fault_r = 1'b1;
            end
        end
        if (faulted_now) begin
            st_nxt.vcnt_r = '0; // [R13] [R14]
        end else if (tick_ms && prof.valid_ms != '0 && !st_r.valid_r) begin
            st_nxt.vcnt_r = v_expire ? '0 : st_r.vcnt_r + 16'h0001; // [R8] [R20]
        end
        if (faulted_now) begin
            st_nxt.valid_r = 1'b0; // [R12]
        end else if (v_expire || ctrl.force_to) begin
            st_nxt.valid_r = !faulted_now; // [R15] [R19]
        end
        st_nxt.redet_r = 1'b0;
        if (!faulted_now || prof.redet_ms == '0 || !auto_sel) begin
            st_nxt.rcnt_r = '0; // [R11]
        end else if (tick_ms) begin
            if (st_r.rcnt_r + 16'h0001 == prof.redet_ms) begin
                st_nxt.redet_r = 1'b1; // [R10]
                st_nxt.rcnt_r = '0;
            end else begin
                st_nxt.rcnt_r = st_r.rcnt_r + 16'h0001; // [R20]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{mon_fault_r: 1'b1, faulted_r: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status.valid = st_r.valid_r;
    assign status.faulted = st_r.faulted_r;
    assign status.redetect = st_r.redet_r;

    fault_blocks_valid_a: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
        st_r.faulted_r |-> !st_r.valid_r)
        else $error("valid high while faulted");
    unstable_faults_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        !stable |=> st_r.mon_fault_r)
        else $error("monitor not faulted before stability");
    bypass_follows_a: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
        ctrl.bypass |=> st_r.faulted_r == $past(ctrl.override))
        else $error("bypass did not follow override");
    timer_halted_a: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        faulted_now |=> st_r.vcnt_r == '0)
        else $error("validation timer ran while faulted");
    force_loads_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        ctrl.force_to && !faulted_now |=> st_r.valid_r)
        else $error("forced timeout did not set valid");
    expire_loads_a: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
        v_expire |=> st_r.valid_r)
        else $error("timer expiry did not set valid");
    zero_redet_a: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        prof.redet_ms == '0 |=> !st_r.redet_r)
        else $error("redetect fired while disabled");
    zero_valid_a: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
        (prof.valid_ms == '0 && !ctrl.force_to && !st_r.valid_r) |=> !st_r.valid_r)
        else $error("valid rose with timer disabled");
    default_source_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        (!ctrl.bypass && !ctrl.override) |=> st_r.faulted_r == $past(st_r.mon_fault_r))
        else $error("faulted differs from monitor fault");
endmodule

//--- logic/ref_supervisor.sv
// Top: register port, stability timer, ms tick and four reference channels
//
// Contract
// [R1] Monitors report faulted until the system clock stability timer expires.
// [R2] Each reference has its own continuous period monitor against its profile.
// [R3] Nominal period is an unsigned 40-bit femtosecond value.
// [R4] Inner and outer tolerances are 20-bit reciprocals; bigger means tighter.
// [R5] A faulted reference clears only within the inner tolerance.
// [R6] A good reference faults only beyond the outer tolerance.
// [R7] Software sets inner tolerance tighter than outer for hysteresis.
// [R8] Per-reference 16-bit millisecond validation timer gates becoming valid.
// [R9] Validation timeout zero disables the timer; software forces validation.
// [R10] Per-reference 16-bit ms redetect timer, only under automatic selection.
// [R11] Redetect timeout zero disables the redetect timer.
// [R12] Faulted high holds the valid latch cleared regardless of controls.
// [R13] A rise of faulted restarts the validation timer.
// [R14] Validation timer counts only while not faulted, else held reset.
// [R15] Timer expiry loads the valid latch with not-faulted.
// [R16] With all controls zero, faulted equals the monitor fault.
// [R17] With bypass set, faulted follows the override bit alone.
// [R18] Without bypass, override forces faulted, else monitor fault.
// [R19] Force timeout bit loads valid like an expiry, then self-clears.
// [R20] A 1 ms tick from the system clock advances both timers.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module ref_supervisor
    import refmon_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [NUM_REFS-1:0] REF_IN,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic [NUM_REFS-1:0] REF_VALID,
    output logic [NUM_REFS-1:0] REF_REDETECT
);
    typedef struct packed {
        logic [31:0] stab_cnt_r;
        logic stable_r;
        logic [31:0] tick_cnt_r;
        logic tick_r;
        logic [NUM_REFS-1:0] force_r;
        logic [7:0] override_r;
        logic [7:0] bypass_r;
        logic [NUM_REFS-1:0] auto_r;
        logic [7:0] rdata_r;
        profile_t [NUM_REFS-1:0] prof_r;
    } top_t;

    top_t s_r;
    top_t s_nxt;
    ref_status_t [NUM_REFS-1:0] stat;
    logic [NUM_REFS-1:0] valid_v;
    logic [NUM_REFS-1:0] fault_v;
    logic [NUM_REFS-1:0] redet_v;

    function automatic logic [7:0] prof_byte(input profile_t p, input logic [3:0] idx);
        logic [8*15-1:0] flat;
        flat = {p.redet_ms, p.valid_ms, 4'h0, p.outer_tol, 4'h0, p.inner_tol, p.period_fs};
        return flat[idx*8 +: 8];
    endfunction

    always_comb begin
        logic [11:0] rel;
        logic [1:0] ch;
        logic [3:0] bi;
        logic [8*15-1:0] flat;
        rel = ADDR - PROFILE_BASE_ADDR;
        ch = rel[5:4];
        bi = rel[3:0];
        flat = '0;
        s_nxt = s_r;
        // Stability timer, then free-running ms tick
        if (!s_r.stable_r) begin
            if (s_r.stab_cnt_r == 32'(STABLE_CYCLES - 1)) begin
                s_nxt.stable_r = 1'b1; // [R1]
            end else begin
                s_nxt.stab_cnt_r = s_r.stab_cnt_r + 32'h1;
            end
        end
        s_nxt.tick_r = 1'b0;
        if (s_r.stable_r) begin
            if (s_r.tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
                s_nxt.tick_cnt_r = '0;
                s_nxt.tick_r = 1'b1; // [R20]
            end else begin
                s_nxt.tick_cnt_r = s_r.tick_cnt_r + 32'h1;
            end
        end
        s_nxt.force_r = '0; // [R19]
        if (WR) begin
            if (ADDR == FORCE_VALIDATION_TIMEOUT_ADDR) begin
                s_nxt.force_r = WDATA[NUM_REFS-1:0]; // [R19]
            end else if (ADDR == MONITOR_OVERRIDE_CONTROL_ADDR) begin
                s_nxt.override_r = {4'h0, WDATA[NUM_REFS-1:0]};
            end else if (ADDR == MONITOR_BYPASS_CONTROL_ADDR) begin
                s_nxt.bypass_r = {4'h0, WDATA[NUM_REFS-1:0]};
            end else if (ADDR == PROFILE_SEL_ADDR) begin
                s_nxt.auto_r = WDATA[NUM_REFS-1:0];
            end else if (ADDR >= PROFILE_BASE_ADDR && rel < 12'h040 && bi <= PRF_LAST) begin
                // Profiles stored as written; tolerance order is software's job [R7]
                flat = {s_r.prof_r[ch].redet_ms, s_r.prof_r[ch].valid_ms, 4'h0,
                        s_r.prof_r[ch].outer_tol, 4'h0, s_r.prof_r[ch].inner_tol,
                        s_r.prof_r[ch].period_fs};
                flat[bi*8 +: 8] = WDATA;
                s_nxt.prof_r[ch].period_fs = flat[PERIOD_W-1:0]; // [R3]
                s_nxt.prof_r[ch].inner_tol = flat[40 +: TOL_W]; // [R4]
                s_nxt.prof_r[ch].outer_tol = flat[64 +: TOL_W]; // [R4]
                s_nxt.prof_r[ch].valid_ms = flat[88 +: TIMER_W];
                s_nxt.prof_r[ch].redet_ms = flat[104 +: TIMER_W];
            end
        end
        s_nxt.rdata_r = 8'h00;
        if (RD) begin
            if (ADDR == MONITOR_OVERRIDE_CONTROL_ADDR) begin
                s_nxt.rdata_r = s_r.override_r;
            end else if (ADDR == MONITOR_BYPASS_CONTROL_ADDR) begin
                s_nxt.rdata_r = s_r.bypass_r;
            end else if (ADDR == PROFILE_SEL_ADDR) begin
                s_nxt.rdata_r = {4'h0, s_r.auto_r};
            end else if (ADDR == REF_STATUS_ADDR) begin
                s_nxt.rdata_r = {fault_v, valid_v};
            end else if (ADDR >= PROFILE_BASE_ADDR && rel < 12'h040 && bi <= PRF_LAST) begin
                s_nxt.rdata_r = prof_byte(s_r.prof_r[ch], bi);
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_r <= '{override_r: OVERRIDE_RESET, bypass_r: BYPASS_RESET, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REFS; g++) begin : g_ch
            ref_channel u_ch (
                .clk(SYS_CLK),
                .rst_b(RST_B),
                .stable(s_r.stable_r),
                .tick_ms(s_r.tick_r),
                .ref_in(REF_IN[g]),
                .prof(s_r.prof_r[g]),
                .ctrl('{bypass: s_r.bypass_r[g], override: s_r.override_r[g],
                        force_to: s_r.force_r[g]}),
                .auto_sel(s_r.auto_r[g]),
                .status(stat[g])
            );
            assign valid_v[g] = stat[g].valid;
            assign fault_v[g] = stat[g].faulted;
            assign redet_v[g] = stat[g].redetect;
        end
    endgenerate

    assign RDATA = s_r.rdata_r;
    assign REF_VALID = valid_v;
    assign REF_REDETECT = redet_v;

    force_self_clears_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // [R19]
        s_r.force_r != '0 |=> (s_r.force_r == '0 || $past(WR)))
        else $error("force bit did not self clear");
    tick_spacing_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // [R20]
        s_r.tick_r |=> !s_r.tick_r)
        else $error("ms tick longer than one cycle");
    no_valid_early_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // [R1]
        !s_r.stable_r && s_r.bypass_r == '0 && s_r.override_r == '0 |-> fault_v == '1)
        else $error("reference not faulted before stability");
endmodule

//--- tb/ref_source.sv
// Partner model: one reference clock source with a programmable period
`timescale 1ns/10ps
module ref_source (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] period,
    output logic ref_out
);
    logic [7:0] cnt_r;
    logic [7:0] per_r;

    // Period of zero means a dead source; the line then sits at its pull-down level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 8'h00;
            per_r <= 8'h00;
            ref_out <= 1'b0;
        end else if (period == 8'h00) begin
            cnt_r <= 8'h00;
            per_r <= 8'h00;
            ref_out <= 1'b0;
        end else begin
            ref_out <= (cnt_r < (per_r >> 1));
            if (cnt_r + 8'h01 >= per_r) begin
                cnt_r <= 8'h00;
                // New period taken only at a cycle boundary, so no runt pulse
                per_r <= period;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the reference supervisor
`timescale 1ns/10ps
module testbench;
    import refmon_pkg::*;

    logic SYS_CLK;
    logic RST_B;
    logic [NUM_REFS-1:0] REF_IN;
    logic [ADDR_W-1:0] ADDR;
    logic [7:0] WDATA;
    logic WR;
    logic RD;
    logic [7:0] RDATA;
    logic [NUM_REFS-1:0] REF_VALID;
    logic [NUM_REFS-1:0] REF_REDETECT;
    logic [7:0] per [NUM_REFS];
    int bad_count;
    int tests_run;
    int cycles;

    ref_supervisor u_ref_supervisor (
        .SYS_CLK(SYS_CLK),
        .RST_B(RST_B),
        .REF_IN(REF_IN),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .WR(WR),
        .RD(RD),
        .RDATA(RDATA),
        .REF_VALID(REF_VALID),
        .REF_REDETECT(REF_REDETECT)
    );

    for (genvar i = 0; i < NUM_REFS; i++) begin : g_src
        ref_source u_src (.clk(SYS_CLK), .rst_b(RST_B), .period(per[i]), .ref_out(REF_IN[i]));
    end

    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run is about 83200 cycles; ceiling leaves some margin
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            bad_count = bad_count + 1;
            conclude();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask

    // 100-cycle nominal period, 2 % inner and 5 % outer window
    task automatic prog(input int n, input logic [15:0] vms, input logic [15:0] rms);
        logic [119:0] v;
        v = {rms, vms, 4'h0, 20'h00014, 4'h0, 20'h00032, 40'h02540BE400};
        for (int b = 0; b < 15; b++) begin
            wr(PROFILE_BASE_ADDR + PROFILE_STRIDE * 12'(n) + 12'(b), v[8*b +: 8]);
        end
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rd(MONITOR_OVERRIDE_CONTROL_ADDR, d);
        check("override reset", d, OVERRIDE_RESET);
        rd(MONITOR_BYPASS_CONTROL_ADDR, d);
        check("bypass reset", d, BYPASS_RESET);
        rd(12'hFFF, d);
        check("unmapped read", d, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_prestable();
        logic [7:0] d;
        for (int n = 0; n < NUM_REFS; n++) begin
            // Two ticks for ref 0, so a restart cannot slip past a short look
            prog(n, (n == 3) ? 16'h0000 : ((n == 0) ? 16'h0002 : 16'h0001),
                 (n == 2) ? 16'h0001 : 16'h0000);
        end
        wr(FORCE_VALIDATION_TIMEOUT_ADDR, 8'h0F);
        wait_cyc(10);
        rd(REF_STATUS_ADDR, d);
        check("status before stable", d, 8'hF0);
        check("valid before stable", 8'(REF_VALID), 8'h00);
        $display("test prestable done");
    endtask

    task automatic t_timer();
        logic [7:0] d;
        rd(REF_STATUS_ADDR, d);
        check("status after timers", d, 8'h07);
        wr(FORCE_VALIDATION_TIMEOUT_ADDR, 8'h08);
        wait_cyc(5);
        check("valid after force", 8'(REF_VALID), 8'h0F);
        rd(FORCE_VALIDATION_TIMEOUT_ADDR, d);
        check("force reads zero", d, 8'h00);
        $display("test timer done");
    endtask

    task automatic t_override();
        wr(MONITOR_OVERRIDE_CONTROL_ADDR, 8'h01);
        wait_cyc(5);
        check("override drops valid", 8'(REF_VALID), 8'h0E);
        wr(MONITOR_OVERRIDE_CONTROL_ADDR, 8'h00);
        wait_cyc(5);
        check("timer restarted", 8'(REF_VALID), 8'h0E);
        wait_cyc(2 * TICK_CYCLES);
        check("valid after expiry", 8'(REF_VALID), 8'h0F);
        $display("test override done");
    endtask

    task automatic t_bypass();
        wr(MONITOR_BYPASS_CONTROL_ADDR, 8'h02);
        per[1] <= 8'd110;
        wait_cyc(500);
        check("bypass hides monitor", 8'(REF_VALID), 8'h0F);
        wr(MONITOR_OVERRIDE_CONTROL_ADDR, 8'h02);
        wait_cyc(5);
        check("bypass follows override", 8'(REF_VALID), 8'h0D);
        wr(MONITOR_OVERRIDE_CONTROL_ADDR, 8'h00);
        wait_cyc(TICK_CYCLES + 10);
        check("bypass override clear", 8'(REF_VALID), 8'h0F);
        wr(MONITOR_BYPASS_CONTROL_ADDR, 8'h00);
        wait_cyc(10);
        check("monitor fault back", 8'(REF_VALID), 8'h0D);
        $display("test bypass done");
    endtask

    task automatic t_hyst();
        per[1] <= 8'd103;
        wait_cyc(500);
        check("faulted stays out", 8'(REF_VALID), 8'h0D);
        per[2] <= 8'd103;
        wait_cyc(500);
        check("good stays in", 8'(REF_VALID), 8'h0D);
        per[1] <= 8'd100;
        per[2] <= 8'd100;
        wait_cyc(TICK_CYCLES + 500);
        check("recovered", 8'(REF_VALID), 8'h0F);
        $display("test hysteresis done");
    endtask

    task automatic t_redet();
        int c0;
        int c2;
        c0 = 0;
        c2 = 0;
        wr(MONITOR_OVERRIDE_CONTROL_ADDR, 8'h01);
        per[2] <= 8'd110;
        wr(PROFILE_SEL_ADDR, 8'h05);
        repeat (TICK_CYCLES + 500) begin
            @(posedge SYS_CLK);
            #1;
            c0 = c0 + int'(REF_REDETECT[0]);
            c2 = c2 + int'(REF_REDETECT[2]);
        end
        check("redetect fires", 8'(c2 != 0), 8'h01);
        check("redetect disabled", 8'(c0), 8'h00);
        $display("test redetect done");
    endtask

    initial begin
        RST_B = 1'b0;
        ADDR = '0;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        for (int i = 0; i < NUM_REFS; i++) begin
            per[i] = 8'd100;
        end
        repeat (8) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        t_reset();
        t_prestable();
        wait_cyc(STABLE_CYCLES + 2 * TICK_CYCLES + 500);
        t_timer();
        t_override();
        t_bypass();
        t_hyst();
        t_redet();
        conclude();
    end
endmodule
